// ---- pin_change_params.svh ----
// Constants for the pin change edge interrupt block.
// Assumes inclusion by bare name from any design file; definitions only.
`ifndef PIN_CHANGE_PARAMS_SVH
`define PIN_CHANGE_PARAMS_SVH

// Register word offsets (byte address = 4 * index)
`define OFS_PA_RISE   4'h0
`define OFS_PA_FALL   4'h1
`define OFS_PA_FLAGS  4'h2
`define OFS_PB_RISE   4'h3
`define OFS_PB_FALL   4'h4
`define OFS_PB_FLAGS  4'h5
`define OFS_PC_RISE   4'h6
`define OFS_PC_FALL   4'h7
`define OFS_PC_FLAGS  4'h8
`define OFS_PE_RISE   4'h9
`define OFS_PE_FALL   4'hA
`define OFS_PE_FLAGS  4'hB
`define OFS_IRQ_EN    4'hC
`define OFS_IRQ_REQ   4'hD

// Field positions
`define PE_BIT        3
`define IRQ_EN_BIT    0
`define SUMMARY_BIT   0

// Reset value and port E bit mask
`define RST_BYTE      8'h00
`define PE_MASK       8'h08

`endif

// ---- pin_change_pkg.sv ----
// Types shared by the pin change edge interrupt block.
// Assumes nothing of its surroundings.
package pin_change_pkg;
   typedef logic [7:0] byte_t;   // One register's payload
   // Bus slave answer phase
   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ACK  = 1'b1
   } bus_state_e;
endpackage

// ---- pin_sync.sv ----
// Two-flop synchroniser for a vector of pin levels.
// Assumes asynchronous pins; the output is safe on clk_sys_in.
`timescale 1ns/1ns
module pin_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk_sys_in,  // System clock
   input  wire logic             reset_in,    // Async reset, high
   input  wire logic [WIDTH-1:0] pin_in,      // Raw pin levels
   output      logic [WIDTH-1:0] sync_out     // Synchronised levels
);
   logic [WIDTH-1:0] meta_r;   // First stage, read only by second

   // Two stages in series
   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         meta_r   <= '0;
         sync_out <= '0;
      end else begin
         meta_r   <= pin_in;
         sync_out <= meta_r;
      end
   end
endmodule

// ---- edge_flag_bank.sv ----
// One port's edge detectors and sticky flags, one entry per pin.
// Assumes synchronised pin levels and same-clock write strobes.
`timescale 1ns/1ns
`include "pin_change_params.svh"
module edge_flag_bank #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk_sys_in,   // System clock
   input  wire logic             reset_in,     // Async reset, high
   input  wire logic [WIDTH-1:0] level_in,     // Synchronised pins
   input  wire logic [WIDTH-1:0] rise_en_in,   // Rising arm bits
   input  wire logic [WIDTH-1:0] fall_en_in,   // Falling arm bits
   input  wire logic             wr_in,        // Flag write strobe
   input  wire logic [WIDTH-1:0] wdata_in,     // Flag write data
   output      logic [WIDTH-1:0] flags_out     // Sticky flags
);
   logic [WIDTH-1:0] prev_r;   // Last sample for compare
   wire  [WIDTH-1:0] hit_w;    // Armed edge seen this cycle

   // Previous sample; reset to zero so a high pin at release
   // reads as one rising edge only if armed
   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) prev_r <= '0;
      else          prev_r <= level_in;
   end

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_pin
         wire rise_w = level_in[i] & ~prev_r[i];
         wire fall_w = ~level_in[i] & prev_r[i];
         assign hit_w[i] = (rise_w & rise_en_in[i]) | (fall_w & fall_en_in[i]);
      end
   endgenerate

   // Hardware set beats software clear: an edge in the write cycle
   // survives whatever value is written
   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in)   flags_out <= '0;
      else if (wr_in) flags_out <= wdata_in | hit_w;
      else            flags_out <= flags_out | hit_w;
   end
endmodule

// ---- pin_change_edge_interrupt.sv ----
// Top of the pin change edge interrupt block with its Avalon-MM slave.
// Assumes pins are asynchronous; bus master shares clk_sys_in.
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "pin_change_params.svh"

// How it works
// - Enabled edge raises interrupt and wake request
// - Sleep edge is flagged before wake completes
// - Port A rising enable register, eight bits
// - Port A falling enable register, eight bits
// - Port A flag sets on armed edge
// - Writing zero clears a flag bit
// - Port B rising enable register, eight bits
// - Port B falling enable register, eight bits
// - Port B flag sets on armed edge
// - Port C rising enable register, eight bits
// - Port C falling enable register, eight bits
// - Port C flag sets on armed edge
// - Port E rising enable only bit three
// - Port E other bits read zero
// - All enables and flags reset to zero
// - Flags software writable, hardware settable
// - Detection continues while interrupt disabled
// - Summary flag ORs every pin flag
// - Edge during clear leaves flag set
// - Port E falling enable and flag bit three
module pin_change_edge_interrupt (
   input  wire logic        clk_sys_in,       // System clock, 10 MHz
   input  wire logic        reset_in,         // Async reset, high
   input  wire logic [7:0]  porta_pin_in,     // Port A pins
   input  wire logic [7:0]  portb_pin_in,     // Port B pins
   input  wire logic [7:0]  portc_pin_in,     // Port C pins
   input  wire logic        porte_pin3_in,    // Port E pin 3
   input  wire logic [5:0]  avs_address_in,   // Word address
   input  wire logic        avs_read_in,      // Read request
   input  wire logic        avs_write_in,     // Write request
   input  wire logic [31:0] avs_writedata_in, // Write data
   input  wire logic [3:0]  avs_byteenable_in,// Byte lanes
   output      logic [31:0] avs_readdata_out, // Read data
   output      logic        avs_waitrequest_out, // Stall
   output      logic [1:0]  avs_response_out, // 00 ok, 10 slave error
   output      logic        irq_out,          // Interrupt request
   output      logic        wake_out          // Wake from Sleep
);
   // Enable registers
   pin_change_pkg::byte_t pa_rise_r, pa_fall_r;
   pin_change_pkg::byte_t pb_rise_r, pb_fall_r;
   pin_change_pkg::byte_t pc_rise_r, pc_fall_r;
   logic                  pe_rise_r, pe_fall_r;   // Only bit 3 exists
   logic                  irq_en_r;               // change_irq_enable
   pin_change_pkg::bus_state_e bus_state_r;       // Answer phase

   // Synchronised pins
   logic [7:0] pa_lvl, pb_lvl, pc_lvl;
   logic [0:0] pe_lvl;
   // Flag banks outputs
   logic [7:0] pa_flags, pb_flags, pc_flags;
   logic [0:0] pe_flags;

   // Pin synchronisers
   pin_sync #(.WIDTH(8)) u_sync_a (
      .clk_sys_in (clk_sys_in), .reset_in (reset_in),
      .pin_in     (porta_pin_in), .sync_out (pa_lvl));
   pin_sync #(.WIDTH(8)) u_sync_b (
      .clk_sys_in (clk_sys_in), .reset_in (reset_in),
      .pin_in     (portb_pin_in), .sync_out (pb_lvl));
   pin_sync #(.WIDTH(8)) u_sync_c (
      .clk_sys_in (clk_sys_in), .reset_in (reset_in),
      .pin_in     (portc_pin_in), .sync_out (pc_lvl));
   pin_sync #(.WIDTH(1)) u_sync_e (
      .clk_sys_in (clk_sys_in), .reset_in (reset_in),
      .pin_in     (porte_pin3_in), .sync_out (pe_lvl));

   // Access decode; a write lands at the edge that sees waitrequest low
   wire        acc_w    = (avs_read_in | avs_write_in)
                          && (bus_state_r == pin_change_pkg::BUS_IDLE);
   wire        wr_w     = avs_write_in && avs_byteenable_in[0]
                          && (bus_state_r == pin_change_pkg::BUS_ACK);
   wire [3:0]  idx_w    = avs_address_in[3:0];
   wire        mapped_w = (avs_address_in[5:4] == 2'b00) && (idx_w <= `OFS_IRQ_REQ);
   wire [7:0]  wd_w     = avs_writedata_in[7:0];
   wire        wr_pa_r_w = wr_w && mapped_w && (idx_w == `OFS_PA_RISE);
   wire        wr_pa_f_w = wr_w && mapped_w && (idx_w == `OFS_PA_FALL);
   wire        wr_pa_g_w = wr_w && mapped_w && (idx_w == `OFS_PA_FLAGS);
   wire        wr_pb_r_w = wr_w && mapped_w && (idx_w == `OFS_PB_RISE);
   wire        wr_pb_f_w = wr_w && mapped_w && (idx_w == `OFS_PB_FALL);
   wire        wr_pb_g_w = wr_w && mapped_w && (idx_w == `OFS_PB_FLAGS);
   wire        wr_pc_r_w = wr_w && mapped_w && (idx_w == `OFS_PC_RISE);
   wire        wr_pc_f_w = wr_w && mapped_w && (idx_w == `OFS_PC_FALL);
   wire        wr_pc_g_w = wr_w && mapped_w && (idx_w == `OFS_PC_FLAGS);
   wire        wr_pe_r_w = wr_w && mapped_w && (idx_w == `OFS_PE_RISE);
   wire        wr_pe_f_w = wr_w && mapped_w && (idx_w == `OFS_PE_FALL);
   wire        wr_pe_g_w = wr_w && mapped_w && (idx_w == `OFS_PE_FLAGS);
   wire        wr_ie_w   = wr_w && mapped_w && (idx_w == `OFS_IRQ_EN);

   // Flag banks, hardware set wins over software clear
   edge_flag_bank #(.WIDTH(8)) u_bank_a (
      .clk_sys_in (clk_sys_in), .reset_in (reset_in), .level_in (pa_lvl),
      .rise_en_in (pa_rise_r), .fall_en_in (pa_fall_r),
      .wr_in (wr_pa_g_w), .wdata_in (wd_w), .flags_out (pa_flags));
   edge_flag_bank #(.WIDTH(8)) u_bank_b (
      .clk_sys_in (clk_sys_in), .reset_in (reset_in), .level_in (pb_lvl),
      .rise_en_in (pb_rise_r), .fall_en_in (pb_fall_r),
      .wr_in (wr_pb_g_w), .wdata_in (wd_w), .flags_out (pb_flags));
   edge_flag_bank #(.WIDTH(8)) u_bank_c (
      .clk_sys_in (clk_sys_in), .reset_in (reset_in), .level_in (pc_lvl),
      .rise_en_in (pc_rise_r), .fall_en_in (pc_fall_r),
      .wr_in (wr_pc_g_w), .wdata_in (wd_w), .flags_out (pc_flags));
   edge_flag_bank #(.WIDTH(1)) u_bank_e (
      .clk_sys_in (clk_sys_in), .reset_in (reset_in), .level_in (pe_lvl),
      .rise_en_in (pe_rise_r), .fall_en_in (pe_fall_r),
      .wr_in (wr_pe_g_w), .wdata_in (wd_w[`PE_BIT:`PE_BIT]), .flags_out (pe_flags));

   // Summary of every flag
   wire summary_w = (|pa_flags) | (|pb_flags) | (|pc_flags) | pe_flags[0];

   // Port E bytes: only bit 3 lives, the rest read zero
   wire [7:0] pe_rise_byte_w  = {4'h0, pe_rise_r, 3'h0};
   wire [7:0] pe_fall_byte_w  = {4'h0, pe_fall_r, 3'h0};
   wire [7:0] pe_flags_byte_w = {4'h0, pe_flags[0], 3'h0};

   // Read multiplexer
   logic [7:0] rd_byte_w;
   always_comb begin
      case (idx_w)
         `OFS_PA_RISE:  rd_byte_w = pa_rise_r;
         `OFS_PA_FALL:  rd_byte_w = pa_fall_r;
         `OFS_PA_FLAGS: rd_byte_w = pa_flags;
         `OFS_PB_RISE:  rd_byte_w = pb_rise_r;
         `OFS_PB_FALL:  rd_byte_w = pb_fall_r;
         `OFS_PB_FLAGS: rd_byte_w = pb_flags;
         `OFS_PC_RISE:  rd_byte_w = pc_rise_r;
         `OFS_PC_FALL:  rd_byte_w = pc_fall_r;
         `OFS_PC_FLAGS: rd_byte_w = pc_flags;
         `OFS_PE_RISE:  rd_byte_w = pe_rise_byte_w;
         `OFS_PE_FALL:  rd_byte_w = pe_fall_byte_w;
         `OFS_PE_FLAGS: rd_byte_w = pe_flags_byte_w;
         `OFS_IRQ_EN:   rd_byte_w = {7'h00, irq_en_r};
         `OFS_IRQ_REQ:  rd_byte_w = {7'h00, summary_w};
         default:       rd_byte_w = `RST_BYTE;
      endcase
   end
   wire [7:0] rd_sel_w = mapped_w ? rd_byte_w : `RST_BYTE;

   // Enable registers, port A and B
   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         pa_rise_r <= `RST_BYTE;
         pa_fall_r <= `RST_BYTE;
         pb_rise_r <= `RST_BYTE;
         pb_fall_r <= `RST_BYTE;
      end else begin
         if (wr_pa_r_w) pa_rise_r <= wd_w;
         if (wr_pa_f_w) pa_fall_r <= wd_w;
         if (wr_pb_r_w) pb_rise_r <= wd_w;
         if (wr_pb_f_w) pb_fall_r <= wd_w;
      end
   end

   // Enable registers, port C and E, plus block enable
   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         pc_rise_r <= `RST_BYTE;
         pc_fall_r <= `RST_BYTE;
         pe_rise_r <= 1'b0;
         pe_fall_r <= 1'b0;
         irq_en_r  <= 1'b0;
      end else begin
         if (wr_pc_r_w) pc_rise_r <= wd_w;
         if (wr_pc_f_w) pc_fall_r <= wd_w;
         if (wr_pe_r_w) pe_rise_r <= wd_w[`PE_BIT];
         if (wr_pe_f_w) pe_fall_r <= wd_w[`PE_BIT];
         if (wr_ie_w)   irq_en_r  <= wd_w[`IRQ_EN_BIT];
      end
   end

   // Bus answer: one wait cycle, then data with waitrequest low.
   // Costs a cycle per access but keeps readdata from a flop.
   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         bus_state_r         <= pin_change_pkg::BUS_IDLE;
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out    <= 32'h0000_0000;
         avs_response_out    <= 2'h0;
      end else if (acc_w) begin
         bus_state_r         <= pin_change_pkg::BUS_ACK;
         avs_waitrequest_out <= 1'b0;
         avs_readdata_out    <= {24'h000000, rd_sel_w};
         avs_response_out    <= mapped_w ? 2'h0 : 2'h2;
      end else begin
         bus_state_r         <= pin_change_pkg::BUS_IDLE;
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out    <= avs_readdata_out;
         avs_response_out    <= avs_response_out;
      end
   end

   // Interrupt and wake: flags keep working when disabled
   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         irq_out  <= 1'b0;
         wake_out <= 1'b0;
      end else begin
         irq_out  <= irq_en_r & summary_w;
         wake_out <= irq_en_r & summary_w;
      end
   end

   // Pending flag with the interrupt enabled is followed by interrupt next cycle
   a_irq_follows: assert property (
      @(posedge clk_sys_in) disable iff (reset_in)
      (irq_en_r && summary_w) |=> irq_out)
      else $error("interrupt not raised for pending flag");

   a_irq_blocked: assert property (
      @(posedge clk_sys_in) disable iff (reset_in)
      (!irq_en_r) |=> !irq_out)
      else $error("interrupt raised while disabled");

   a_wake_flagged: assert property (
      @(posedge clk_sys_in) disable iff (reset_in)
      $rose(wake_out) |-> $past(summary_w))
      else $error("wake without a recorded flag");

   a_pa_rise_set: assert property (
      @(posedge clk_sys_in) disable iff (reset_in)
      (pa_lvl[0] && !u_bank_a.prev_r[0] && pa_rise_r[0]) |=> pa_flags[0])
      else $error("port A rising edge not flagged");

   a_pb_fall_set: assert property (
      @(posedge clk_sys_in) disable iff (reset_in)
      (!pb_lvl[7] && u_bank_b.prev_r[7] && pb_fall_r[7]) |=> pb_flags[7])
      else $error("port B falling edge not flagged");

   a_pc_unarmed: assert property (
      @(posedge clk_sys_in) disable iff (reset_in)
      (!pc_flags[2] && pc_rise_r[2] == 1'b0 && pc_fall_r[2] == 1'b0 && !wr_pc_g_w)
      |=> !pc_flags[2])
      else $error("port C flag set while unarmed");

   a_clear_race: assert property (
      @(posedge clk_sys_in) disable iff (reset_in)
      (wr_pa_g_w && !wd_w[0] && pa_lvl[0] && !u_bank_a.prev_r[0] && pa_rise_r[0])
      |=> pa_flags[0])
      else $error("edge lost during flag clear");

   a_clear_zero: assert property (
      @(posedge clk_sys_in) disable iff (reset_in)
      (wr_pb_g_w && !wd_w[0] && !(pb_lvl[0] ^ u_bank_b.prev_r[0])) |=> !pb_flags[0])
      else $error("flag not cleared by zero write");

   a_summary_or: assert property (
      @(posedge clk_sys_in) disable iff (reset_in)
      (idx_w == `OFS_IRQ_REQ && avs_read_in && acc_w)
      |=> avs_readdata_out[`SUMMARY_BIT] == $past(summary_w))
      else $error("summary read disagrees with flags");

   a_pe_unused: assert property (
      @(posedge clk_sys_in) disable iff (reset_in)
      (acc_w && avs_read_in && (idx_w == `OFS_PE_RISE || idx_w == `OFS_PE_FLAGS))
      |=> (avs_readdata_out[7:0] & ~`PE_MASK) == 8'h00)
      else $error("port E unimplemented bits not zero");

   // Every armed edge kind on each port leaves its flag set
   a_pa_fall_set: assert property (
      @(posedge clk_sys_in) disable iff (reset_in)
      (!pa_lvl[7] && u_bank_a.prev_r[7] && pa_fall_r[7]) |=> pa_flags[7])
      else $error("port A falling edge not flagged");

   a_pb_rise_set: assert property (
      @(posedge clk_sys_in) disable iff (reset_in)
      (pb_lvl[3] && !u_bank_b.prev_r[3] && pb_rise_r[3]) |=> pb_flags[3])
      else $error("port B rising edge not flagged");

   a_pc_rise_set: assert property (
      @(posedge clk_sys_in) disable iff (reset_in)
      (pc_lvl[5] && !u_bank_c.prev_r[5] && pc_rise_r[5]) |=> pc_flags[5])
      else $error("port C rising edge not flagged");

   a_pc_fall_set: assert property (
      @(posedge clk_sys_in) disable iff (reset_in)
      (!pc_lvl[0] && u_bank_c.prev_r[0] && pc_fall_r[0]) |=> pc_flags[0])
      else $error("port C falling edge not flagged");

   a_pe_rise_set: assert property (
      @(posedge clk_sys_in) disable iff (reset_in)
      (pe_lvl[0] && !u_bank_e.prev_r[0] && pe_rise_r) |=> pe_flags[0])
      else $error("port E rising edge not flagged");

   a_pe_fall_set: assert property (
      @(posedge clk_sys_in) disable iff (reset_in)
      (!pe_lvl[0] && u_bank_e.prev_r[0] && pe_fall_r) |=> pe_flags[0])
      else $error("port E falling edge not flagged");

   // Enable writes take the written byte, bit 3 only for port E, at the answering edge
   a_pa_rise_write: assert property (
      @(posedge clk_sys_in) disable iff (reset_in)
      wr_pa_r_w |=> pa_rise_r == $past(wd_w))
      else $error("port A rising enable not written");

   a_pa_fall_write: assert property (
      @(posedge clk_sys_in) disable iff (reset_in)
      wr_pa_f_w |=> pa_fall_r == $past(wd_w))
      else $error("port A falling enable not written");

   a_pb_rise_write: assert property (
      @(posedge clk_sys_in) disable iff (reset_in)
      wr_pb_r_w |=> pb_rise_r == $past(wd_w))
      else $error("port B rising enable not written");

   a_pb_fall_write: assert property (
      @(posedge clk_sys_in) disable iff (reset_in)
      wr_pb_f_w |=> pb_fall_r == $past(wd_w))
      else $error("port B falling enable not written");

   a_pc_rise_write: assert property (
      @(posedge clk_sys_in) disable iff (reset_in)
      wr_pc_r_w |=> pc_rise_r == $past(wd_w))
      else $error("port C rising enable not written");

   a_pc_fall_write: assert property (
      @(posedge clk_sys_in) disable iff (reset_in)
      wr_pc_f_w |=> pc_fall_r == $past(wd_w))
      else $error("port C falling enable not written");

   a_pe_rise_write: assert property (
      @(posedge clk_sys_in) disable iff (reset_in)
      wr_pe_r_w |=> pe_rise_r == $past(wd_w[`PE_BIT]))
      else $error("port E rising enable not written");

   a_pe_fall_write: assert property (
      @(posedge clk_sys_in) disable iff (reset_in)
      wr_pe_f_w |=> pe_fall_r == $past(wd_w[`PE_BIT]))
      else $error("port E falling enable not written");

   // Bus answer: one stall cycle, one answer cycle, error on holes; wake request equals interrupt
   a_wait_answer: assert property (
      @(posedge clk_sys_in) disable iff (reset_in)
      acc_w |=> !avs_waitrequest_out)
      else $error("accepted access not answered");

   a_wait_single: assert property (
      @(posedge clk_sys_in) disable iff (reset_in)
      !avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("waitrequest low for more than one cycle");

   a_resp_unmapped: assert property (
      @(posedge clk_sys_in) disable iff (reset_in)
      (acc_w && !mapped_w) |=> avs_response_out == 2'h2)
      else $error("unmapped access not refused");

   a_wake_irq: assert property (
      @(posedge clk_sys_in) disable iff (reset_in)
      wake_out == irq_out)
      else $error("wake request differs from interrupt");
endmodule

// ---- pin_source.sv ----
// Model of the external circuits that drive the port pins.
// Assumes the bench commands it on the rising edge of clk_sys_in.
`timescale 1ns/1ns
module pin_source (
   input  wire logic        clk_sys_in, // System clock
   input  wire logic        set_in,     // Apply new levels
   input  wire logic [24:0] level_in,   // Port E3, C, B, A levels
   output      logic [24:0] pins_out    // Levels seen at the pins
);
   // Pins are always driven, so no released level is ever modelled
   initial pins_out = 25'h0;
   // New levels land one edge after the command, like a real driver
   always @(posedge clk_sys_in) begin
      if (set_in) begin
         pins_out <= level_in;
      end
   end
endmodule

// ---- test_pin_change_edge_interrupt.sv ----
// Self-checking bench for the pin change edge interrupt block.
// Assumes the design files and pin_source are compiled before it.
`timescale 1ns/1ns
`include "pin_change_params.svh"
module test_pin_change_edge_interrupt;
   logic        clk_sys_in;  // System clock
   logic        reset_in;    // Async reset, high
   logic [5:0]  addr;        // Bus word index
   logic        rd_en;       // Bus read
   logic        wr_en;       // Bus write
   logic [31:0] wdata;       // Bus write data
   logic [3:0]  lanes;       // Bus byte enables
   logic [31:0] rdata;       // Bus read data
   logic        stall;       // Bus waitrequest
   logic [1:0]  resp;        // Bus response
   logic        irq_out;     // Interrupt level
   logic        wake_out;    // Wake level
   logic        set_in;      // Pin model command
   logic [24:0] level_in;    // Pin model levels
   logic [24:0] pins;        // Levels at the pins
   logic [24:0] lvl;         // Bench copy of pin levels
   logic [7:0]  ren [4];     // Expected rising enables
   logic [7:0]  fen [4];     // Expected falling enables
   logic [7:0]  flg [4];     // Expected flags
   logic [33:0] exp_q [$];   // Expected response and data of reads
   int          failures;    // Mismatches
   int          comparisons; // Comparisons made
   int          seed;        // Seeding result, unused

   pin_change_edge_interrupt DUT (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
      .porta_pin_in(pins[7:0]), .portb_pin_in(pins[15:8]), .portc_pin_in(pins[23:16]),
      .porte_pin3_in(pins[24]), .avs_address_in(addr), .avs_read_in(rd_en),
      .avs_write_in(wr_en), .avs_writedata_in(wdata), .avs_byteenable_in(lanes),
      .avs_readdata_out(rdata), .avs_waitrequest_out(stall), .avs_response_out(resp),
      .irq_out(irq_out), .wake_out(wake_out));
   pin_source partner (.clk_sys_in(clk_sys_in), .set_in(set_in), .level_in(level_in),
      .pins_out(pins));

   // Clock, 100 ns period
   always #50 clk_sys_in = ~clk_sys_in;

   // Byte view of one port; port E has bit 3 only
   function automatic logic [7:0] port_bits(input int p, input logic [24:0] v);
      return (p < 3) ? v[p*8 +: 8] : {4'h0, v[24], 3'h0};
   endfunction

   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // One bus access held until waitrequest is sampled low
   task automatic bus_op(input logic r, input int i, input logic [7:0] d, input logic [3:0] be);
      rd_en <= r;
      wr_en <= !r;
      addr <= 6'(i);
      wdata <= {24'h0, d};
      lanes <= be;
      // Only the watchdog ends a wait that never answers
      do begin
         @(posedge clk_sys_in);
      end while (stall !== 1'b0);
      rd_en <= 1'b0;
      wr_en <= 1'b0;
      @(posedge clk_sys_in);
   endtask

   task automatic rd(input int i, input logic [7:0] d, input logic [1:0] rs);
      exp_q.push_back({rs, 24'h0, d});
      bus_op(1'b1, i, 8'h00, 4'hF);
   endtask

   task automatic wr(input int i, input logic [7:0] d);
      bus_op(1'b0, i, d, 4'hF);
   endtask

   task automatic set_en(input int p, input logic [7:0] r, input logic [7:0] f);
      ren[p] = (p < 3) ? r : r & `PE_MASK;
      fen[p] = (p < 3) ? f : f & `PE_MASK;
      wr(3*p, r);
      wr(3*p+1, f);
      rd(3*p, ren[p], 2'b00);
      rd(3*p+1, fen[p], 2'b00);
   endtask

   // Armed edges are booked as flags, then the pins change
   task automatic move(input logic [24:0] nv);
      for (int p = 0; p < 4; p++)
         flg[p] |= (~port_bits(p, lvl) & port_bits(p, nv) & ren[p])
                 | (port_bits(p, lvl) & ~port_bits(p, nv) & fen[p]);
      lvl = nv;
      level_in <= nv;
      set_in <= 1'b1;
      @(posedge clk_sys_in);
      set_in <= 1'b0;
      repeat (5) @(posedge clk_sys_in);
   endtask

   task automatic check_flags(input logic ie);
      logic pending;   // Any flag booked
      pending = |{flg[0], flg[1], flg[2], flg[3]};
      for (int p = 0; p < 4; p++) rd(3*p+2, flg[p], 2'b00);
      rd(`OFS_IRQ_REQ, {7'h0, pending}, 2'b00);
      check({32'h0, irq_out, wake_out}, {32'h0, ie & pending, ie & pending});
   endtask

   // Read results are compared in the order they were booked
   always @(posedge clk_sys_in) begin
      if (rd_en === 1'b1 && stall === 1'b0) begin
         if (exp_q.size() == 0) check(34'h0, 34'h1);
         else check({resp, rdata}, exp_q.pop_front());
      end
   end

   // Watchdog, far beyond the few hundred cycles needed
   initial begin
      #2000000;
      failures++;
      report_and_stop();
   end

   initial begin
      {clk_sys_in, rd_en, wr_en, set_in, addr, wdata, lanes} = '0;
      {reset_in, level_in, lvl, failures, comparisons} = '0;
      reset_in = 1'b1;
      for (int p = 0; p < 4; p++) {ren[p], fen[p], flg[p]} = '0;
      seed = $urandom(69);
      repeat (6) @(posedge clk_sys_in);
      reset_in <= 1'b0;
      @(posedge clk_sys_in);
      for (int i = 0; i < 14; i++) rd(i, 8'h00, 2'b00);
      rd(6'h2A, 8'h00, 2'b10);                          // unmapped index refused
      bus_op(1'b0, 0, 8'h5A, 4'h0);
      rd(0, 8'h00, 2'b00);                              // lane 0 off, write ignored
      for (int p = 0; p < 3; p++) set_en(p, 8'($urandom), 8'($urandom));
      set_en(3, 8'hFF, 8'hFF);
      for (int k = 0; k < 8; k++) begin
         move(25'($urandom));
         check_flags(1'b0);
      end
      wr(`OFS_IRQ_EN, 8'h01);
      move(~lvl);
      check_flags(1'b1);
      for (int p = 0; p < 4; p++) wr(3*p+2, 8'h00);
      for (int p = 0; p < 4; p++) flg[p] = 8'h00;
      repeat (5) @(posedge clk_sys_in);
      check_flags(1'b1);
      wr(11, 8'hFF);
      wr(2, 8'h81);
      flg[3] = `PE_MASK;
      flg[0] = 8'h81;
      check_flags(1'b1);
      set_en(0, 8'hFF, 8'h00);
      move(lvl & ~25'h1);
      wr(2, 8'h00);
      wr(11, 8'h00);
      lvl = lvl | 25'h1;
      level_in <= lvl;
      set_in <= 1'b1;
      @(posedge clk_sys_in);
      set_in <= 1'b0;
      // Write answer edge meets the armed edge on pin A0
      repeat (1) @(posedge clk_sys_in);
      wr(2, 8'h00);
      flg[0] = 8'h01;
      flg[3] = 8'h00;
      check_flags(1'b1);
      reset_in <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      reset_in <= 1'b0;
      @(posedge clk_sys_in);
      for (int i = 0; i < 14; i++) rd(i, 8'h00, 2'b00);
      check({32'h0, irq_out, wake_out}, 34'h0);
      report_and_stop();
   end
endmodule
